// [verilog/port_owner_params.svh]
`ifndef PORT_OWNER_PARAMS_SVH
`define PORT_OWNER_PARAMS_SVH
// register byte offsets
`define PORT1_OFFSET 12'h064
`define PORT2_OFFSET 12'h068
`define CONFIG_OFFSET 12'h06c
`define CAPABILITY_OFFSET 12'h070
// field positions inside the port register
`define TEST_LSB 16
`define TEST_MSB 19
`define OWNER_BIT 13
`define POWER_BIT 12
`define LINE_DP_BIT 11
`define LINE_DM_BIT 10
`define CONNECT_BIT 0
`define ENABLE_BIT 2
// field positions in the config and capability registers
`define CONFIG_BIT 0
`define POWER_CAP_BIT 4
// test code values
`define TEST_NONE 4'h0
`define TEST_FORCE_ENABLE 4'h5
`define TEST_LAST_LEGAL 4'h5
// reset values
`define OWNER_RESET 1'b1
`define POWER_RESET 1'b0
`define TEST_RESET 4'h0
`define CAP_RESET 1'b1
`define ZERO_WORD 32'h0000_0000
`endif

// [verilog/port_owner_pkg.sv]
package port_owner_pkg;
   // apb slave phases
   typedef enum logic [1:0] {
      idle_type_s = 2'b00,
      access_s = 2'b01
   } apb_phase_type;
   // per port control fields
   typedef struct packed {
      logic [3:0] test_code;
      logic owner;
      logic power;
   } port_ctrl_type;
endpackage : port_owner_pkg

// [verilog/port_field_if.sv]
`timescale 1ns/1ns
// write request and state shared between the bank and one port field slice
interface port_field_if;
   logic wr;                    // write strobe for this port
   logic [31:0] wdata;          // write data
   logic configure_flag;        // global configure flag
   logic config_rise;           // configure flag went 0 to 1
   logic power_switch_capability;
   logic overcurrent;           // overcurrent seen on the port
   logic [31:0] rdata;          // assembled read word
   logic test_active;
   logic force_enable;
   logic test_reserved;
   logic companion_owned;
   logic power_on;
   modport bank (output wr, output wdata, output configure_flag, output config_rise,
      output power_switch_capability, output overcurrent,
      input rdata, input test_active, input force_enable, input test_reserved,
      input companion_owned, input power_on);
   modport slice (input wr, input wdata, input configure_flag, input config_rise,
      input power_switch_capability, input overcurrent,
      output rdata, output test_active, output force_enable, output test_reserved,
      output companion_owned, output power_on);
endinterface : port_field_if

// [verilog/port_field_slice.sv]
`timescale 1ns/1ns
`include "port_owner_params.svh"
// one port's test code, ownership and power bits plus its read word
module port_field_slice (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic line_dp,
   input wire logic line_dm,
   input wire logic connect_status,
   input wire logic port_enable,
   port_field_if.slice pf
);
   port_owner_pkg::port_ctrl_type ctrl; // stored fields
   logic next_owner;                    // owner value for next cycle
   logic next_power;                    // power value for next cycle
   logic [3:0] next_test;               // test code for next cycle
   logic power_bit;                     // power as software sees it
   logic line_valid;                    // line state meaningful now

   // ownership: held high while flag low, forced low on flag rise
   assign next_owner = !pf.configure_flag ? 1'b1 :
      pf.config_rise ? 1'b0 :
      pf.wr ? pf.wdata[`OWNER_BIT] : ctrl.owner;
   // power: writable only with switches; overcurrent cuts it
   assign next_power = !pf.power_switch_capability ? 1'b1 :
      (pf.overcurrent && ctrl.power) ? 1'b0 :
      pf.wr ? pf.wdata[`POWER_BIT] : ctrl.power;
   assign next_test = pf.wr ? pf.wdata[`TEST_MSB:`TEST_LSB] : ctrl.test_code;
   assign power_bit = pf.power_switch_capability ? ctrl.power : 1'b1;
   // line state only meaningful when powered, connected and disabled
   assign line_valid = power_bit && connect_status && !port_enable;

   // field registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl.owner <= `OWNER_RESET;
         ctrl.power <= `POWER_RESET;
         ctrl.test_code <= `TEST_RESET;
      end
      else
      begin
         ctrl.owner <= next_owner;
         ctrl.power <= next_power;
         ctrl.test_code <= next_test;
      end
   end

   // read word: bits 15 and 14 always zero
   always_comb
   begin
      pf.rdata = `ZERO_WORD;
      pf.rdata[`TEST_MSB:`TEST_LSB] = ctrl.test_code;
      pf.rdata[`OWNER_BIT] = ctrl.owner;
      pf.rdata[`POWER_BIT] = power_bit;
      if (power_bit)
      begin
         pf.rdata[`LINE_DP_BIT] = line_valid & line_dp;
         pf.rdata[`LINE_DM_BIT] = line_valid & line_dm;
         pf.rdata[`ENABLE_BIT] = port_enable;
         pf.rdata[`CONNECT_BIT] = connect_status;
      end
   end

   // test code decode
   assign pf.test_active = (ctrl.test_code != `TEST_NONE);
   assign pf.force_enable = (ctrl.test_code == `TEST_FORCE_ENABLE);
   assign pf.test_reserved = (ctrl.test_code > `TEST_LAST_LEGAL);
   assign pf.companion_owned = ctrl.owner;
   assign pf.power_on = power_bit;
endmodule : port_field_slice

// [verilog/port_owner_bank.sv]
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "port_owner_params.svh"
// Summary of operation
// - code 0101b forced enable, above reserved
// - zero test code means normal operation
// - ownership bit resets to one
// - configure flag rise clears ownership bit
// - ownership held one while flag zero
// - ownership one routes port to companion
// - no switches: power reads one always
// - with switches power bit drives switch
// - unpowered port reports no status
// - overcurrent may clear power bit
// - line state shows data lines, bits 11,10
// - line state valid only disabled and connected
// - line state undefined when unpowered
module port_owner_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] positive_data_line,
   input wire logic [1:0] negative_data_line,
   input wire logic [1:0] connect_status,
   input wire logic [1:0] port_enable,
   input wire logic [1:0] overcurrent,
   output logic [1:0] companion_owned,
   output logic [1:0] port_power_switch,
   output logic [1:0] test_active,
   output logic [1:0] force_enable,
   output logic [1:0] test_reserved
);
   logic configure_flag;         // global configure flag
   logic power_switch_capability; // switch capability flag
   logic [31:0] next_prdata;     // read mux result
   logic setup;                  // setup phase seen
   logic hit_port1;              // address decodes
   logic hit_port2;
   logic hit_config;
   logic hit_cap;
   logic mapped;
   logic write_now;              // write takes effect
   logic next_flag;              // configure flag next value
   logic config_rise;            // flag rise this cycle

   port_field_if pf1 ();
   port_field_if pf2 ();

   // address decode, one word per register
   assign hit_port1 = (paddr == `PORT1_OFFSET);
   assign hit_port2 = (paddr == `PORT2_OFFSET);
   assign hit_config = (paddr == `CONFIG_OFFSET);
   assign hit_cap = (paddr == `CAPABILITY_OFFSET);
   assign mapped = hit_port1 | hit_port2 | hit_config | hit_cap;
   // setup phase goes straight into a one-cycle access with pready
   assign setup = psel && !penable;
   assign write_now = psel && penable && pready && pwrite;
   assign next_flag = (write_now && hit_config) ? pwdata[`CONFIG_BIT] : configure_flag;
   assign config_rise = next_flag && !configure_flag;

   // read mux, unmapped reads zero
   assign next_prdata = hit_port1 ? pf1.rdata :
      hit_port2 ? pf2.rdata :
      hit_config ? {31'h0000_0000, configure_flag} :
      hit_cap ? {27'h000_0000, power_switch_capability, 4'h0} : `ZERO_WORD;

   // slice connections
   assign pf1.wr = write_now && hit_port1;
   assign pf2.wr = write_now && hit_port2;
   assign pf1.wdata = pwdata;
   assign pf2.wdata = pwdata;
   assign pf1.configure_flag = next_flag;
   assign pf2.configure_flag = next_flag;
   assign pf1.config_rise = config_rise;
   assign pf2.config_rise = config_rise;
   assign pf1.power_switch_capability = power_switch_capability;
   assign pf2.power_switch_capability = power_switch_capability;
   assign pf1.overcurrent = overcurrent[0];
   assign pf2.overcurrent = overcurrent[1];

   // port 1 fields
   port_field_slice u_port1 (
      .pclk(pclk),
      .presetn(presetn),
      .line_dp(positive_data_line[0]),
      .line_dm(negative_data_line[0]),
      .connect_status(connect_status[0]),
      .port_enable(port_enable[0]),
      .pf(pf1.slice)
   );

   // port 2 fields
   port_field_slice u_port2 (
      .pclk(pclk),
      .presetn(presetn),
      .line_dp(positive_data_line[1]),
      .line_dm(negative_data_line[1]),
      .connect_status(connect_status[1]),
      .port_enable(port_enable[1]),
      .pf(pf2.slice)
   );

   // global flag and capability
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         configure_flag <= 1'b0;
         power_switch_capability <= `CAP_RESET;
      end
      else
      begin
         configure_flag <= next_flag;
         if (write_now && hit_cap)
            power_switch_capability <= pwdata[`POWER_CAP_BIT];
      end
   end

   // apb answer: pready one cycle after setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `ZERO_WORD;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= setup ? next_prdata : `ZERO_WORD;
      end
   end

   // registered port side outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         companion_owned <= 2'b11;
         port_power_switch <= 2'b00;
         test_active <= 2'b00;
         force_enable <= 2'b00;
         test_reserved <= 2'b00;
      end
      else
      begin
         companion_owned <= {pf2.companion_owned, pf1.companion_owned};
         port_power_switch <= {pf2.power_on, pf1.power_on};
         test_active <= {pf2.test_active, pf1.test_active};
         force_enable <= {pf2.force_enable, pf1.force_enable};
         test_reserved <= {pf2.test_reserved, pf1.test_reserved};
      end
   end
endmodule : port_owner_bank

// [dv/port_owner_bank_props.sv]
`timescale 1ns/1ns
module port_owner_bank_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [1:0] connect_status,
   input wire logic [1:0] port_enable,
   input wire logic [1:0] overcurrent,
   input wire logic [1:0] companion_owned,
   input wire logic [1:0] port_power_switch,
   input wire logic [1:0] test_active,
   input wire logic [1:0] force_enable,
   input wire logic [1:0] test_reserved
);
   logic cfg_q; // configure flag as software last wrote it
   logic cap_q; // power switch capability as last written
   wire wr_done = psel && penable && pready && pwrite; // committed write
   wire rd_port = pready && !pwrite && (paddr == 12'h064 || paddr == 12'h068); // port read answer
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow copies of the flag and capability bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_q <= 1'b0;
         cap_q <= 1'b1;
      end
      else if (wr_done && paddr == 12'h06c)
         cfg_q <= pwdata[0];
      else if (wr_done && paddr == 12'h070)
         cap_q <= pwdata[4];
   end
   sequence cfg_set;
      wr_done && paddr == 12'h06c && pwdata[0] && !cfg_q;
   endsequence
   sequence cfg_low;
      !cfg_q && !$past(cfg_q) && !$past(cfg_q, 2);
   endsequence
   sequence cap_low;
      !cap_q && !$past(cap_q) && !$past(cap_q, 2);
   endsequence
   ready_one_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   reserved_excl_a: assert property (test_reserved[0] |-> test_active[0] && !force_enable[0])
      else $error("reserved test code decode wrong");
   force_active_a: assert property (force_enable[0] |-> test_active[0])
      else $error("forced enable without test mode");
   owner_clear_a: assert property (cfg_set |-> ##[1:3] companion_owned == 2'b00)
      else $error("ownership not cleared on flag rise");
   owner_held_a: assert property (cfg_low |-> companion_owned == 2'b11)
      else $error("ownership not held while flag low");
   power_fixed_a: assert property (cap_low |-> port_power_switch == 2'b11)
      else $error("power off without switches");
   oc_cut_a: assert property (overcurrent[0] && cap_q && port_power_switch[0] |-> ##[1:3] !port_power_switch[0])
      else $error("overcurrent left power on");
   line_quiet_a: assert property (rd_port && paddr == 12'h064 && !(connect_status[0] && !port_enable[0])
      |-> prdata[11:10] == 2'b00) else $error("line state shown when invalid");
   reserved_zero_a: assert property (rd_port |-> prdata[15:14] == 2'b00) else $error("bits 15:14 not zero");
endmodule : port_owner_bank_props
bind port_owner_bank port_owner_bank_props u_port_owner_bank_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .connect_status, .port_enable, .overcurrent, .companion_owned,
   .port_power_switch, .test_active, .force_enable, .test_reserved);

// [dv/usb_device_model.sv]
`timescale 1ns/1ns
// devices on the two downstream ports; a detached port sits low through the host pull-downs
module usb_device_model (
   input wire logic pclk,
   input wire logic [1:0] attached,
   input wire logic [3:0] line_code,
   input wire logic [1:0] fault,
   output logic [1:0] positive_data_line = 2'b00,
   output logic [1:0] negative_data_line = 2'b00,
   output logic [1:0] connect_status = 2'b00,
   output logic [1:0] overcurrent = 2'b00
);
   // line levels per port, {positive, negative} in line_code
   always_ff @(posedge pclk)
   begin
      positive_data_line <= attached & {line_code[3], line_code[1]};
      negative_data_line <= attached & {line_code[2], line_code[0]};
      connect_status <= attached;
      overcurrent <= fault;
   end
endmodule : usb_device_model

// [dv/test_port_owner_bank.sv]
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module test_port_owner_bank;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [1:0] positive_data_line, negative_data_line, connect_status, overcurrent;
   logic [1:0] companion_owned, port_power_switch, test_active, force_enable, test_reserved;
   logic [1:0] attached = 2'b00;
   logic [1:0] port_enable = 2'b00;
   logic [1:0] fault = 2'b00;
   logic [3:0] line_code = 4'h0;
   int failures = 0;
   int cmp_count = 0;
   always #10 pclk = ~pclk;
   port_owner_bank u_port_owner_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .positive_data_line, .negative_data_line, .connect_status, .port_enable,
      .overcurrent, .companion_owned, .port_power_switch, .test_active, .force_enable, .test_reserved);
   usb_device_model u_usb_device_model (.pclk, .attached, .line_code, .fault, .positive_data_line,
      .negative_data_line, .connect_status, .overcurrent);
   task automatic report_and_stop;
      if (failures == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   // one apb transfer; request held until pready is seen high at a rising edge,
   // read data and error are taken at that same edge, then the request drops
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         failures++;
         report_and_stop();
      end
   endtask : apb
   // outputs follow the register one cycle later; stimulus stays on rising edges
   task automatic settle;
      repeat (2) @(posedge pclk);
   endtask : settle
   task automatic t_reset;
      apb(1'b0, 12'h064, 32'h0);
      `CHK("port1", 32'h0000_2000, rd)
      `CHK("owned", 2'b11, companion_owned)
      apb(1'b0, 12'h100, 32'h0);
      `CHK("unmapped", 1'b1, err)
   endtask : t_reset
   task automatic t_owner;
      apb(1'b1, 12'h06c, 32'h1);
      settle();
      `CHK("owned", 2'b00, companion_owned)
      apb(1'b1, 12'h064, 32'h0000_2000);
      settle();
      `CHK("owned", 2'b01, companion_owned)
      apb(1'b1, 12'h06c, 32'h0);
      apb(1'b1, 12'h068, 32'h0);
      settle();
      `CHK("owned", 2'b11, companion_owned)
      apb(1'b1, 12'h06c, 32'h1);
   endtask : t_owner
   task automatic t_power;
      apb(1'b1, 12'h064, 32'h0000_1000);
      settle();
      `CHK("switch", 1'b1, port_power_switch[0])
      fault <= 2'b01;
      repeat (4) @(posedge pclk);
      `CHK("switch", 2'b00, port_power_switch)
      fault <= 2'b00;
      apb(1'b1, 12'h070, 32'h0);
      settle();
      `CHK("switch", 2'b11, port_power_switch)
      apb(1'b0, 12'h064, 32'h0);
      `CHK("power", 1'b1, rd[12])
      apb(1'b1, 12'h070, 32'h10);
   endtask : t_power
   task automatic t_test;
      for (int c = 0; c < 16; c++)
      begin
         apb(1'b1, 12'h064, {12'h000, c[3:0], 16'hc000});
         settle();
         `CHK("active", c != 0, test_active[0])
         `CHK("forced", c == 5, force_enable[0])
         `CHK("reserved", c > 5, test_reserved[0])
      end
      apb(1'b0, 12'h064, 32'h0);
      `CHK("upper", 6'h3c, rd[19:14])
   endtask : t_test
   task automatic t_line;
      apb(1'b1, 12'h064, 32'h0000_1000);
      attached <= 2'b01;
      for (int s = 0; s < 4; s++)
      begin
         line_code <= {2'b00, s[1:0]};
         settle();
         apb(1'b0, 12'h064, 32'h0);
         `CHK("line", s[1:0], rd[11:10])
         // software reacts: k-state hands the port over, anything else keeps it
         if (rd[11:10] == 2'b01)
            apb(1'b1, 12'h064, 32'h0000_3000);
         else
            apb(1'b1, 12'h064, 32'h0000_1000);
         settle();
         `CHK("handover", (s == 1), companion_owned[0])
      end
      apb(1'b1, 12'h064, 32'h0000_1000);
      port_enable <= 2'b01;
      apb(1'b0, 12'h064, 32'h0);
      `CHK("line", 2'b00, rd[11:10])
      port_enable <= 2'b00;
      apb(1'b1, 12'h064, 32'h0);
      apb(1'b0, 12'h064, 32'h0);
      `CHK("unpowered", 3'b000, {rd[11:10], rd[0]})
   endtask : t_line
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_owner();
      t_power();
      t_test();
      t_line();
      report_and_stop();
   end
endmodule : test_port_owner_bank
